// ==== logic/rf_synth_divider_control.sv ====
// Purpose: RF half of a dual synthesizer: serial word decode, dividers, pump control
// Assumes: Serial clock, data, latch, reference and VCO inputs are synchronous
// Notes:   Pump high-impedance follows its bit within two clocks of the latch while the loop runs; powerdown forces it on
`timescale 1ns/1ps
module rf_synth_divider_control
    import rf_synth_pkg::*;
#(
    parameter logic HIGH_BAND_VARIANT = 1'b1
)(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    // Three-wire programming port
    input  wire logic ser_clock_i,
    input  wire logic ser_data_i,
    input  wire logic ser_latch_i,
    // Divider inputs
    input  wire logic ref_in_i,
    input  wire logic vco_in_i,
    // Divider and pump outputs
    output logic      ref_pulse_o,
    output logic      fb_pulse_o,
    output logic      pump_up_o,
    output logic      pump_down_o,
    output logic      pump_gain_high_o,
    output logic      pump_hiz_o,
    output logic      loop_active_o
);
    import rf_synth_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Serial word capture

    function automatic logic word_hit(input logic [WORD_W-1:0] w, input logic [1:0] a);
        word_hit = (w[ADDR_W-1:0] == a);
    endfunction

    logic              ser_clk_q;
    logic              latch_q;
    logic              ref_in_q;
    logic              vco_in_q;
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] rf_reference_word_q;
    logic [WORD_W-1:0] rf_feedback_word_q;
    logic              latch_rise;

    assign latch_rise = ser_latch_i & ~latch_q;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ser_clk_q <= 1'b0;
            latch_q   <= 1'b0;
            ref_in_q  <= 1'b0;
            vco_in_q  <= 1'b0;
        end else begin
            ser_clk_q <= ser_clock_i;
            latch_q   <= ser_latch_i;
            ref_in_q  <= ref_in_i;
            vco_in_q  <= vco_in_i;
        end
    end

    // Most significant bit first; the address ends in bits [1:0]
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            shift_q <= '0;
        end else if (ser_clock_i && !ser_clk_q) begin
            shift_q <= {shift_q[WORD_W-2:0], ser_data_i};
        end
    end

    // Words for other addresses belong to the other synthesizer half
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rf_reference_word_q <= RF_REF_RESET;
            rf_feedback_word_q  <= RF_FB_RESET;
        end else if (latch_rise) begin
            if (word_hit(shift_q, ADDR_RF_REF)) begin
                rf_reference_word_q <= shift_q;
            end
            if (word_hit(shift_q, ADDR_RF_FB)) begin
                rf_feedback_word_q <= shift_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field decode

    logic [REF_CNT_W-1:0] rf_reference_count;
    logic [REF_CNT_W-1:0] ref_ratio;
    logic                 rf_detector_polarity;
    logic                 rf_pump_gain_select;
    logic                 rf_pump_high_impedance;
    logic [SWALLOW_W-1:0] rf_swallow_count;
    logic [BIN_W-1:0]     rf_binary_count;
    logic                 rf_prescaler_select;
    logic                 rf_loop_powerdown;
    logic [MOD_W-1:0]     modulus;

    assign rf_reference_count     = rf_reference_word_q[REF_CNT_LSB +: REF_CNT_W];
    // A forbidden ratio below the minimum is run as the minimum
    assign ref_ratio              = (rf_reference_count < REF_MIN) ? REF_MIN
                                                                   : rf_reference_count;
    assign rf_detector_polarity   = rf_reference_word_q[POL_BIT];
    assign rf_pump_gain_select    = rf_reference_word_q[GAIN_BIT];
    assign rf_pump_high_impedance = rf_reference_word_q[HIZ_BIT];
    assign rf_swallow_count       = rf_feedback_word_q[SWALLOW_LSB +: SWALLOW_W];
    assign rf_binary_count        = rf_feedback_word_q[BIN_LSB +: BIN_W];
    assign rf_prescaler_select    = rf_feedback_word_q[PRESEL_BIT];
    assign rf_loop_powerdown      = rf_feedback_word_q[PWDN_BIT];
    assign modulus = pre_modulus(rf_prescaler_select, HIGH_BAND_VARIANT);

    ////////////////////////////////////////////////////////////////////////////
    // Powerdown sequencing

    pwr_state_t pwr_q;
    logic       run;

    assign run = (pwr_q != PWR_DOWN);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pwr_q <= PWR_DOWN;
        end else begin
            unique case (pwr_q)
                PWR_ACTIVE: begin
                    if (rf_loop_powerdown) begin
                        // High impedance selects the immediate shutdown
                        pwr_q <= rf_pump_high_impedance ? PWR_DOWN : PWR_WAIT;
                    end
                end
                PWR_WAIT: begin
                    if (!rf_loop_powerdown) begin
                        pwr_q <= PWR_ACTIVE;
                    end else if (rf_pump_high_impedance || ref_pulse_o) begin
                        pwr_q <= PWR_DOWN;
                    end
                end
                PWR_DOWN: begin
                    if (!rf_loop_powerdown) begin
                        pwr_q <= PWR_ACTIVE;
                    end
                end
                default: pwr_q <= PWR_DOWN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference divider

    logic [REF_CNT_W-1:0] ref_cnt_q;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            ref_cnt_q   <= '0;
            ref_pulse_o <= 1'b0;
        end else if (!run) begin
            ref_cnt_q   <= ref_ratio - 15'h0001;
            ref_pulse_o <= 1'b0;
        end else if (ref_in_i && !ref_in_q) begin
            if (ref_cnt_q == '0) begin
                ref_cnt_q   <= ref_ratio - 15'h0001;
                ref_pulse_o <= 1'b1;
            end else begin
                ref_cnt_q   <= ref_cnt_q - 15'h0001;
                ref_pulse_o <= 1'b0;
            end
        end else begin
            ref_pulse_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Feedback divider

    rf_fb_divider u_fb_divider (
        .clk_sys_i  (clk_sys_i),
        .resetn_i   (resetn_i),
        .run_i      (run),
        .count_en_i (vco_in_i && !vco_in_q),
        .swallow_i  (rf_swallow_count),
        .binary_i   (rf_binary_count),
        .modulus_i  (modulus),
        .pulse_o    (fb_pulse_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Phase detector and pump

    logic ref_lead_q;
    logic fb_lead_q;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || !run) begin
            ref_lead_q <= 1'b0;
            fb_lead_q  <= 1'b0;
        end else if ((ref_pulse_o || ref_lead_q) && (fb_pulse_o || fb_lead_q)) begin
            ref_lead_q <= 1'b0;
            fb_lead_q  <= 1'b0;
        end else begin
            ref_lead_q <= ref_lead_q | ref_pulse_o;
            fb_lead_q  <= fb_lead_q | fb_pulse_o;
        end
    end

    // Positive tuning slope pumps up when the reference leads
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pump_up_o        <= 1'b0;
            pump_down_o      <= 1'b0;
            pump_gain_high_o <= 1'b0;
            pump_hiz_o       <= 1'b1;
            loop_active_o    <= 1'b0;
        end else begin
            pump_hiz_o       <= rf_pump_high_impedance || !run;
            pump_up_o        <= !rf_pump_high_impedance && run
                                && (rf_detector_polarity ? ref_lead_q : fb_lead_q);
            pump_down_o      <= !rf_pump_high_impedance && run
                                && (rf_detector_polarity ? fb_lead_q : ref_lead_q);
            pump_gain_high_o <= rf_pump_gain_select;
            loop_active_o    <= run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_ref_write;
        latch_rise && word_hit(shift_q, ADDR_RF_REF);
    endsequence

    property p_hiz_quiet;
        pump_hiz_o |-> !pump_up_o && !pump_down_o;
    endproperty
    a_hiz_quiet: assert property (p_hiz_quiet) else $error("pump drives in high impedance");

    property p_hiz_fast;
        s_ref_write ##1 rf_pump_high_impedance |=> pump_hiz_o;
    endproperty
    a_hiz_fast: assert property (p_hiz_fast) else $error("high impedance late");

    property p_gain;
        s_ref_write ##1 1'b1 |=> pump_gain_high_o == $past(shift_q[GAIN_BIT], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("pump gain not applied");

    property p_async_down;
        pwr_q == PWR_ACTIVE && rf_loop_powerdown && rf_pump_high_impedance
            |=> pwr_q == PWR_DOWN ##1 !loop_active_o;
    endproperty
    a_async_down: assert property (p_async_down) else $error("async powerdown late");

    property p_sync_wait;
        pwr_q == PWR_WAIT && rf_loop_powerdown && !rf_pump_high_impedance && !ref_pulse_o
            |=> pwr_q != PWR_DOWN;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("sync powerdown early");

    property p_sync_done;
        pwr_q == PWR_WAIT && rf_loop_powerdown && !rf_pump_high_impedance && ref_pulse_o
            |=> pwr_q == PWR_DOWN;
    endproperty
    a_sync_done: assert property (p_sync_done) else $error("sync powerdown missed");

    property p_wake;
        pwr_q == PWR_DOWN && !rf_loop_powerdown |=> pwr_q == PWR_ACTIVE ##1 loop_active_o;
    endproperty
    a_wake: assert property (p_wake) else $error("loop not restarted");

    property p_down_quiet;
        pwr_q == PWR_DOWN |=> !ref_pulse_o && !fb_pulse_o;
    endproperty
    a_down_quiet: assert property (p_down_quiet) else $error("divider runs in powerdown");

    property p_ref_spacing;
        ref_pulse_o |=> !ref_pulse_o [*2];
    endproperty
    a_ref_spacing: assert property (p_ref_spacing) else $error("reference ratio below 3");

    property p_pump_excl;
        !(pump_up_o && pump_down_o);
    endproperty
    a_pump_excl: assert property (p_pump_excl) else $error("pump up and down together");

    property p_addr_ignore;
        latch_rise && !word_hit(shift_q, ADDR_RF_FB)
            |=> $stable(rf_feedback_word_q);
    endproperty
    a_addr_ignore: assert property (p_addr_ignore) else $error("feedback word wrongly loaded");
endmodule

// ==== logic/rf_synth_pkg.sv ====
// Purpose: Shared constants for the RF synthesizer divider control block
// Assumes: 22-bit programming words, address in bits [1:0]
// Notes:   Field positions, reset words and moduli live here only
package rf_synth_pkg;
    localparam int WORD_W      = 22;
    localparam int ADDR_W      = 2;
    localparam logic [1:0] ADDR_RF_REF = 2'h2;
    localparam logic [1:0] ADDR_RF_FB  = 2'h3;
    // Reference word fields
    localparam int REF_CNT_LSB = 2;
    localparam int REF_CNT_W   = 15;
    localparam int POL_BIT     = 17;
    localparam int GAIN_BIT    = 18;
    localparam int HIZ_BIT     = 19;
    // Feedback word fields
    localparam int SWALLOW_LSB = 2;
    localparam int SWALLOW_W   = 7;
    localparam int BIN_LSB     = 9;
    localparam int BIN_W       = 11;
    localparam int PRESEL_BIT  = 20;
    localparam int PWDN_BIT    = 21;
    localparam int MOD_W       = 8;
    // Smallest legal counts
    localparam logic [14:0] REF_MIN = 15'h0003;
    localparam logic [10:0] BIN_MIN = 11'h003;
    // Reset words: loop held powered down until the host programs it
    localparam logic [21:0] RF_REF_RESET = 22'h000002;
    localparam logic [21:0] RF_FB_RESET  = 22'h200003;
    // Prescaler moduli (smaller of each pair)
    localparam logic [7:0] MOD_32  = 8'h20;
    localparam logic [7:0] MOD_64  = 8'h40;
    localparam logic [7:0] MOD_128 = 8'h80;

    typedef enum logic [2:0] {
        PWR_ACTIVE = 3'b001,
        PWR_WAIT   = 3'b010,
        PWR_DOWN   = 3'b100
    } pwr_state_t;

    function automatic logic [7:0] pre_modulus(input logic sel, input logic high_band);
        if (high_band) begin
            pre_modulus = sel ? MOD_64 : MOD_32;
        end else begin
            pre_modulus = sel ? MOD_128 : MOD_64;
        end
    endfunction
endpackage

// ==== logic/rf_fb_divider.sv ====
// Purpose: Dual-modulus feedback divider with swallow and binary counters
// Assumes: count_en_i is a one-cycle pulse per prescaler input edge
// Notes:   Division is modulus*binary + swallow; needs binary >= swallow
`timescale 1ns/1ps
module rf_fb_divider
    import rf_synth_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 resetn_i,
    // Control
    input  wire logic                 run_i,
    input  wire logic                 count_en_i,
    input  wire logic [SWALLOW_W-1:0] swallow_i,
    input  wire logic [BIN_W-1:0]     binary_i,
    input  wire logic [MOD_W-1:0]     modulus_i,
    // Divided output
    output logic                      pulse_o
);
    import rf_synth_pkg::*;

    logic [MOD_W:0]       pre_q;
    logic [SWALLOW_W-1:0] a_left_q;
    logic [BIN_W-1:0]     b_left_q;
    logic [SWALLOW_W-1:0] a_nxt;
    logic [BIN_W-1:0]     b_nxt;
    logic                 wrap;

    // Next swallow/binary state after one prescaler cycle
    always_comb begin
        wrap = (b_left_q <= 11'h001);
        if (wrap) begin
            a_nxt = swallow_i;
            b_nxt = (binary_i < BIN_MIN) ? BIN_MIN : binary_i;
        end else begin
            a_nxt = (a_left_q != '0) ? a_left_q - 7'h01 : a_left_q;
            b_nxt = b_left_q - 11'h001;
        end
    end

    // Larger modulus while swallow remains, smaller for the rest
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            pre_q    <= '0;
            a_left_q <= '0;
            b_left_q <= 11'h001;
            pulse_o  <= 1'b0;
        end else if (!run_i) begin
            // Stopped counters restart from a clean load
            a_left_q <= swallow_i;
            b_left_q <= (binary_i < BIN_MIN) ? BIN_MIN : binary_i;
            pre_q    <= (swallow_i != '0) ? {1'b0, modulus_i} : {1'b0, modulus_i} - 9'h001;
            pulse_o  <= 1'b0;
        end else if (count_en_i) begin
            if (pre_q == '0) begin
                a_left_q <= a_nxt;
                b_left_q <= b_nxt;
                pre_q    <= (a_nxt != '0) ? {1'b0, modulus_i} : {1'b0, modulus_i} - 9'h001;
                pulse_o  <= wrap;
            end else begin
                pre_q   <= pre_q - 9'h001;
                pulse_o <= 1'b0;
            end
        end else begin
            pulse_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    property p_fb_single;
        pulse_o |=> !pulse_o;
    endproperty
    a_fb_single: assert property (p_fb_single) else $error("feedback pulse too long");

    property p_fb_stop;
        !run_i |=> !pulse_o;
    endproperty
    a_fb_stop: assert property (p_fb_stop) else $error("feedback pulse while stopped");
endmodule

// ==== tb/rf_host_model.sv ====
// Purpose: Host model driving the three-wire programming port
// Assumes: Caller enters send_word just after a rising clk edge or off-edge
// Notes:   Each serial level holds two clocks; serial clock idles low
`timescale 1ns/1ps
module rf_host_model
    import rf_synth_pkg::*;
(
    // Clock
    input  wire logic clk_sys_i,
    // Serial port
    output logic      ser_clock_o,
    output logic      ser_data_o,
    output logic      ser_latch_o
);
    initial begin
        ser_clock_o = 1'b0;
        ser_data_o  = 1'b0;
        ser_latch_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two clocks per level so every serial edge is seen by the sampled port
    task automatic hold2();
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic send_word(input logic [21:0] word);
        logic [21:0] w;
        w = word;
        if (w[1:0] == ADDR_RF_REF && w[16:2] < REF_MIN) begin
            w[16:2] = REF_MIN;
        end
        if (w[1:0] == ADDR_RF_FB && w[19:9] < BIN_MIN) begin
            w[19:9] = BIN_MIN;
        end
        for (int i = 21; i >= 0; i--) begin
            ser_data_o <= w[i];
            hold2();
            ser_clock_o <= 1'b1;
            hold2();
            ser_clock_o <= 1'b0;
        end
        hold2();
        ser_latch_o <= 1'b1;
        hold2();
        ser_latch_o <= 1'b0;
        // Data no longer meaningful after the frame: show the inverse
        ser_data_o  <= ~w[0];
        @(posedge clk_sys_i);
    endtask
endmodule

// ==== tb/rf_synth_divider_control_tb.sv ====
// Purpose: Self-checking bench for the RF divider control block
// Assumes: High band variant, so prescaler pairs are 32/33 and 64/65
// Notes:   Checks are made 10 ns after an edge so outputs have settled
`timescale 1ns/1ps
module rf_synth_divider_control_tb;
    import rf_synth_pkg::*;
    logic clk_sys_i;
    logic resetn_i;
    logic ref_in_i;
    logic vco_in_i;
    logic ser_clock;
    logic ser_data;
    logic ser_latch;
    logic ref_pulse_o;
    logic fb_pulse_o;
    logic pump_up_o;
    logic pump_down_o;
    logic pump_gain_high_o;
    logic pump_hiz_o;
    logic loop_active_o;
    int   n_errors;
    int   num_checks;
    int   ref_seen;
    int   fb_seen;
    int   base;
    int   n_exp;

    initial clk_sys_i = 1'b0;
    always #50 clk_sys_i = ~clk_sys_i;

    rf_host_model u_host (
        .clk_sys_i   (clk_sys_i),
        .ser_clock_o (ser_clock),
        .ser_data_o  (ser_data),
        .ser_latch_o (ser_latch)
    );

    rf_synth_divider_control #(.HIGH_BAND_VARIANT(1'b1)) u_dut (
        .clk_sys_i        (clk_sys_i),
        .resetn_i         (resetn_i),
        .ser_clock_i      (ser_clock),
        .ser_data_i       (ser_data),
        .ser_latch_i      (ser_latch),
        .ref_in_i         (ref_in_i),
        .vco_in_i         (vco_in_i),
        .ref_pulse_o      (ref_pulse_o),
        .fb_pulse_o       (fb_pulse_o),
        .pump_up_o        (pump_up_o),
        .pump_down_o      (pump_down_o),
        .pump_gain_high_o (pump_gain_high_o),
        .pump_hiz_o       (pump_hiz_o),
        .loop_active_o    (loop_active_o)
    );

    always @(posedge clk_sys_i) begin
        if (ref_pulse_o === 1'b1) ref_seen++;
        if (fb_pulse_o === 1'b1) fb_seen++;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [21:0] ref_w(input logic [14:0] r, input logic pol,
                                          input logic gain, input logic hiz);
        ref_w = {2'b00, hiz, gain, pol, r, ADDR_RF_REF};
    endfunction

    function automatic logic [21:0] fb_w(input logic pd, input logic sel,
                                         input logic [10:0] b, input logic [6:0] a);
        fb_w = {pd, sel, b, a, ADDR_RF_FB};
    endfunction

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Wait covers the three-edge lag of the loop state after the latch
    task automatic write(input logic [21:0] w);
        @(posedge clk_sys_i);
        u_host.send_word(w);
        repeat (4) @(posedge clk_sys_i);
        #10;
    endtask

    task automatic pulse_in(input bit vco, input int n);
        @(posedge clk_sys_i);
        repeat (n) begin
            if (vco) vco_in_i <= 1'b1;
            else ref_in_i <= 1'b1;
            @(posedge clk_sys_i);
            vco_in_i <= 1'b0;
            ref_in_i <= 1'b0;
            @(posedge clk_sys_i);
        end
        repeat (4) @(posedge clk_sys_i);
        #10;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (50000) @(posedge clk_sys_i);
        n_errors++;
        print_verdict();
    end

    initial begin
        resetn_i   = 1'b0;
        ref_in_i   = 1'b0;
        vco_in_i   = 1'b0;
        n_errors   = 0;
        num_checks = 0;
        repeat (16) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        #10;
        check("hiz", pump_hiz_o, 1);
        check("loop", loop_active_o, 0);
        check("gain", pump_gain_high_o, 0);
        $display("test reset done");

        write(ref_w(15'h0003, 1'b1, 1'b1, 1'b0));
        check("gain", pump_gain_high_o, 1);
        check("hiz", pump_hiz_o, 1);
        // Address 00 must be ignored, so gain stays high
        write(ref_w(15'h0003, 1'b1, 1'b0, 1'b0) & 22'h3ffffc);
        check("gain", pump_gain_high_o, 1);
        write(fb_w(1'b0, 1'b0, 11'h003, 7'h01));
        check("loop", loop_active_o, 1);
        check("hiz", pump_hiz_o, 0);
        $display("test programming done");

        // Reference leads, then 32*3+1 vco rises close the comparison
        pulse_in(1'b0, 3);
        check("up", pump_up_o, 1);
        check("down", pump_down_o, 0);
        pulse_in(1'b1, 97);
        check("up", pump_up_o, 0);
        check("down", pump_down_o, 0);
        write(ref_w(15'h0003, 1'b0, 1'b1, 1'b0));
        pulse_in(1'b0, 3);
        check("down", pump_down_o, 1);
        check("up", pump_up_o, 0);
        pulse_in(1'b1, 97);
        $display("test polarity done");

        // Asynchronous powerdown reloads counters before each ratio
        for (int k = 0; k < 2; k++) begin
            write(ref_w(15'h0005, 1'b0, 1'b1, 1'b1));
            check("hiz", pump_hiz_o, 1);
            write(fb_w(1'b1, 1'b0, 11'h003, 7'h00));
            check("loop", loop_active_o, 0);
            // Binary count kept at or above the swallow count so the ratio formula holds
            write(fb_w(1'b0, k[0], 11'(3 + 124 * k), 7'(127 * k)));
            n_exp = (k == 0 ? 32 : 64) * (3 + 124 * k) + 127 * k;
            base = fb_seen;
            for (int j = 0; j < 2; j++) begin
                pulse_in(1'b1, n_exp - 1);
                check("fb_early", 32'(fb_seen - base), 32'(j));
                pulse_in(1'b1, 1);
                check("fb_count", 32'(fb_seen - base), 32'(j + 1));
            end
        end
        base = ref_seen;
        pulse_in(1'b0, 4);
        check("ref_early", 32'(ref_seen - base), 0);
        pulse_in(1'b0, 6);
        check("ref_count", 32'(ref_seen - base), 2);
        $display("test dividers done");

        // Synchronous powerdown waits for the next reference pulse
        write(ref_w(15'h0005, 1'b0, 1'b1, 1'b0));
        check("hiz", pump_hiz_o, 0);
        write(fb_w(1'b1, 1'b0, 11'h003, 7'h00));
        check("loop", loop_active_o, 1);
        pulse_in(1'b0, 5);
        check("loop", loop_active_o, 0);
        check("hiz", pump_hiz_o, 1);
        $display("test powerdown done");
        print_verdict();
    end
endmodule
